// [hdl/fcd_decoder.sv]
// Flash command decoder: turns coded CPU write sequences into flash operations
//
// How it works
// - F0 returns to array read, except while a program or erase runs without error or an erase is suspended
// - A8,54,F0 unlock sequence also returns read
// - Unlock, A0, then data programs a word
// - Unlock,80,unlock,30 at block erases it
// - Same prefix with 10 erases whole chip
// - B0 during erase suspends it
// - Host touches only other blocks while suspended
// - 30 while suspended resumes erase
// - Lock unlock, C0, value to odd word
// - Lock unlock, 90 makes odd words read lock
// - Lock unlock, C1, F0 lifts sector locks
// - FFFF from flash lifts code lock
// - FFFB from flash restores code lock
// - Address bits 14 and up ignored
// - Extra blocks accepted within 96 us window
// - Lock zero bits stay zero, else error
// - Odd word address is 4n-2
// - Bad cycle aborts to array read
`timescale 1ns/1ns
`default_nettype none
module fcd_decoder
    import fcd_pkg::*;
#(
    parameter int WINDOW_CYCLES = WINDOW_CYC,
    parameter int MAX_BLOCKS = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    fcd_if.dev bus,
    input wire logic i_op_done,
    input wire logic i_op_fail,
    input wire logic [DATA_W-1:0] i_array_data,
    output logic o_prog_go,
    output logic o_wipe_go,
    output logic o_chip_wipe,
    output logic [MAX_BLOCKS-1:0] o_wipe_blocks,
    output logic o_wipe_hold,
    output logic [ADDR_W-1:0] o_target_location,
    output logic [DATA_W-1:0] o_prog_data,
    output logic o_lock_write,
    output logic [DATA_W-1:0] o_lock_write_value,
    output logic o_sector_lock_lift,
    output logic o_code_lock_lift,
    output logic [DATA_W-1:0] o_flash_status_word
);
    if (WINDOW_CYCLES < 1 || WINDOW_CYCLES >= (1 << WIN_W)) begin : g_bad_window
        $error("WINDOW_CYCLES out of range");
    end
    if (MAX_BLOCKS < 1 || MAX_BLOCKS > 16) begin : g_bad_blocks
        $error("MAX_BLOCKS must be 1..16");
    end

    typedef struct packed {
        fcd_state_t st;
        fcd_rmode_t rmode;
        logic prog_go;
        logic wipe_go;
        logic chip;
        logic [15:0] blocks;
        logic hold;
        logic [ADDR_W-1:0] tgt;
        logic [DATA_W-1:0] pdata;
        logic lock_wr;
        logic [DATA_W-1:0] lock_val;
        logic [DATA_W-1:0] lock_word;
        logic sec_lift;
        logic code_lift;
        logic [WIN_W-1:0] win_cnt;
        logic err;
        logic tog;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
    } fcd_dec_t;

    fcd_dec_t s_r;
    fcd_dec_t s_nxt;

    function automatic logic cmd_hit(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                                     input logic [13:0] ca, input logic [7:0] cd);
        cmd_hit = (a[13:0] == ca) && (d[7:0] == cd);
    endfunction : cmd_hit

    function automatic logic odd_word(input logic [ADDR_W-1:0] a);
        odd_word = (a[1:0] == 2'b10);
    endfunction : odd_word

    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic is_f0;
    logic [3:0] blk;
    assign a = bus.addr;
    assign d = bus.wdata;
    assign is_f0 = (d[7:0] == CD_F0);
    // Block number taken from the top address bits; real mapping is array-specific
    assign blk = a[ADDR_W-1:ADDR_W-4];

    always_comb begin
        s_nxt = s_r;
        s_nxt.prog_go = 1'b0;
        s_nxt.lock_wr = 1'b0;
        s_nxt.rvalid = bus.rd;
        if ((s_r.st == S_BUSY || s_r.st == S_PROG) && !s_r.err) begin
            s_nxt.tog = ~s_r.tog;
        end
        if (s_r.st == S_WIN && s_r.win_cnt != '0) begin
            s_nxt.win_cnt = s_r.win_cnt - WIN_W'(1);
        end
        if (s_r.st == S_WIN && s_r.win_cnt == '0) begin
            s_nxt.st = S_BUSY;
            s_nxt.wipe_go = 1'b1;
        end
        if ((s_r.st == S_BUSY || s_r.st == S_PROG) && i_op_done) begin
            s_nxt.err = i_op_fail;
            s_nxt.wipe_go = s_r.hold && s_r.wipe_go;
            s_nxt.st = i_op_fail ? s_r.st : (s_r.hold ? S_HOLD : S_READ);
            s_nxt.rmode = i_op_fail ? RM_STATUS : RM_ARRAY;
            if (!i_op_fail && !s_r.hold) begin
                s_nxt.blocks = '0;
            end
        end
        if (bus.wr && bus.from_flash && d == CODE_LIFT) begin
            s_nxt.code_lift = 1'b1;
        end else if (bus.wr && bus.from_flash && d == CODE_RESTORE) begin
            s_nxt.code_lift = 1'b0;
        end else if (bus.wr) begin
            case (s_r.st)
                S_BUSY, S_PROG, S_WIN: begin
                    if (d[7:0] == CD_B0 && s_r.st != S_PROG) begin
                        s_nxt.st = S_HOLD;
                        s_nxt.hold = 1'b1;
                        s_nxt.wipe_go = 1'b1;
                        s_nxt.rmode = RM_ARRAY;
                    end else if (s_r.st == S_WIN && d[7:0] == CD_30) begin
                        s_nxt.blocks[blk] = 1'b1;
                        s_nxt.win_cnt = WIN_W'(WINDOW_CYCLES - 1);
                    end else if (is_f0 && (s_r.err || s_r.st == S_WIN)) begin
                        s_nxt.st = S_READ;
                        s_nxt.err = 1'b0;
                        s_nxt.hold = 1'b0;
                        s_nxt.wipe_go = 1'b0;
                        s_nxt.blocks = '0;
                        s_nxt.rmode = RM_ARRAY;
                    end
                end
                S_HOLD: begin
                    if (d[7:0] == CD_30) begin
                        s_nxt.st = S_BUSY;
                        s_nxt.hold = 1'b0;
                        s_nxt.rmode = RM_STATUS;
                    end else if (cmd_hit(a, d, CA_1554, CD_A8)) begin
                        s_nxt.st = S_U1;
                    end
                end
                S_READ, S_LQRY, S_LIFT: begin
                    s_nxt.rmode = RM_ARRAY;
                    s_nxt.st = S_READ;
                    s_nxt.err = s_r.err && !is_f0;
                    if (s_r.st == S_LIFT && is_f0) begin
                        s_nxt.sec_lift = 1'b1;
                    end else if (cmd_hit(a, d, CA_1554, CD_A8)) begin
                        s_nxt.st = S_U1;
                    end else if (cmd_hit(a, d, CA_2A54, CD_A8)) begin
                        s_nxt.st = S_P1;
                    end
                end
                S_U1: s_nxt.st = cmd_hit(a, d, CA_2AA8, CD_54) ? S_U2 : S_READ;
                S_U2: begin
                    if (cmd_hit(a, d, CA_1554, CD_A0)) begin
                        s_nxt.st = S_PROG;
                    end else if (cmd_hit(a, d, CA_1554, CD_80) && !s_r.hold) begin
                        s_nxt.st = S_ER3;
                    end else begin
                        s_nxt.st = S_READ;
                    end
                end
                S_ER3: s_nxt.st = cmd_hit(a, d, CA_1554, CD_A8) ? S_ER4 : S_READ;
                S_ER4: s_nxt.st = cmd_hit(a, d, CA_2AA8, CD_54) ? S_ER5 : S_READ;
                S_ER5: begin
                    if (cmd_hit(a, d, CA_1554, CD_10)) begin
                        s_nxt.st = S_BUSY;
                        s_nxt.chip = 1'b1;
                        s_nxt.wipe_go = 1'b1;
                        s_nxt.rmode = RM_STATUS;
                    end else if (d[7:0] == CD_30) begin
                        s_nxt.st = S_WIN;
                        s_nxt.chip = 1'b0;
                        s_nxt.blocks = '0;
                        s_nxt.blocks[blk] = 1'b1;
                        s_nxt.win_cnt = WIN_W'(WINDOW_CYCLES - 1);
                        s_nxt.rmode = RM_STATUS;
                    end else begin
                        s_nxt.st = S_READ;
                    end
                end
                S_P1: s_nxt.st = cmd_hit(a, d, CA_15A8, CD_54) ? S_P2 : S_READ;
                S_P2: begin
                    if (cmd_hit(a, d, CA_2A54, CD_C0)) begin
                        s_nxt.st = S_LSET;
                    end else if (cmd_hit(a, d, CA_2A54, CD_90)) begin
                        s_nxt.st = S_LQRY;
                        s_nxt.rmode = RM_LOCK;
                    end else if (cmd_hit(a, d, CA_2A54, CD_C1)) begin
                        s_nxt.st = S_LIFT;
                    end else begin
                        s_nxt.st = S_READ;
                    end
                end
                S_LSET: begin
                    s_nxt.st = S_READ;
                    if (odd_word(a)) begin
                        s_nxt.lock_wr = 1'b1;
                        s_nxt.lock_val = d;
                        s_nxt.err = |(~s_r.lock_word & d);
                        s_nxt.lock_word = s_r.lock_word & d;
                        s_nxt.rmode = s_nxt.err ? RM_STATUS : RM_ARRAY;
                    end
                end
                default: s_nxt.st = S_READ;
            endcase
        end
        if (bus.wr && s_r.st == S_PROG && s_r.prog_go == 1'b0 && s_r.rmode != RM_STATUS) begin
            s_nxt.prog_go = 1'b1;
            s_nxt.tgt = a;
            s_nxt.pdata = d;
            s_nxt.rmode = RM_STATUS;
        end
        if (bus.rd) begin
            case (s_r.rmode)
                RM_STATUS: s_nxt.rdata = o_flash_status_word;
                RM_LOCK: s_nxt.rdata = odd_word(a) ? s_r.lock_word : i_array_data;
                default: s_nxt.rdata = i_array_data;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_r <= '0;
            s_r.st <= S_READ;
            s_r.rmode <= RM_ARRAY;
            s_r.lock_word <= LOCK_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        o_flash_status_word = '0;
        o_flash_status_word[STAT_DONE] = (s_r.st != S_BUSY && s_r.st != S_PROG) || s_r.err;
        o_flash_status_word[STAT_TOG] = s_r.tog;
        o_flash_status_word[STAT_TOG2] = s_r.tog;
        o_flash_status_word[STAT_ERR] = s_r.err;
        o_flash_status_word[STAT_WIN] = (s_r.st != S_WIN);
    end

    assign o_prog_go = s_r.prog_go;
    assign o_wipe_go = s_r.wipe_go && !s_r.hold && s_r.st == S_BUSY;
    assign o_chip_wipe = s_r.chip;
    assign o_wipe_blocks = s_r.blocks[MAX_BLOCKS-1:0];
    assign o_wipe_hold = s_r.hold;
    assign o_target_location = s_r.tgt;
    assign o_prog_data = s_r.pdata;
    assign o_lock_write = s_r.lock_wr;
    assign o_lock_write_value = s_r.lock_val;
    assign o_sector_lock_lift = s_r.sec_lift;
    assign o_code_lock_lift = s_r.code_lift;
    assign bus.rdata = s_r.rdata;
    assign bus.rvalid = s_r.rvalid;
endmodule : fcd_decoder
`default_nettype wire

// [hdl/fcd_pkg.sv]
// Shared constants and types for the flash command decoder and its CPU-side driver
package fcd_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam logic [13:0] CA_1554 = 14'h1554;
    localparam logic [13:0] CA_2AA8 = 14'h2AA8;
    localparam logic [13:0] CA_2A54 = 14'h2A54;
    localparam logic [13:0] CA_15A8 = 14'h15A8;
    localparam logic [7:0] CD_A8 = 8'hA8;
    localparam logic [7:0] CD_54 = 8'h54;
    localparam logic [7:0] CD_A0 = 8'hA0;
    localparam logic [7:0] CD_80 = 8'h80;
    localparam logic [7:0] CD_30 = 8'h30;
    localparam logic [7:0] CD_10 = 8'h10;
    localparam logic [7:0] CD_B0 = 8'hB0;
    localparam logic [7:0] CD_C0 = 8'hC0;
    localparam logic [7:0] CD_C1 = 8'hC1;
    localparam logic [7:0] CD_90 = 8'h90;
    localparam logic [7:0] CD_F0 = 8'hF0;
    localparam logic [15:0] CODE_LIFT = 16'hFFFF;
    localparam logic [15:0] CODE_RESTORE = 16'hFFFB;
    localparam logic [15:0] LOCK_RESET = 16'hFFFF;
    localparam int WINDOW_NS = 96000;
    localparam int CLK_NS = 4;
    localparam int WINDOW_CYC = WINDOW_NS / CLK_NS;
    localparam int WIN_W = 15;
    localparam int STAT_DONE = 7;
    localparam int STAT_TOG = 6;
    localparam int STAT_ERR = 5;
    localparam int STAT_WIN = 3;
    localparam int STAT_TOG2 = 2;
    typedef enum logic [3:0] {
        S_READ = 4'b0000, S_U1 = 4'b0001, S_U2 = 4'b0010, S_ER3 = 4'b0011,
        S_ER4 = 4'b0100, S_ER5 = 4'b0101, S_PROG = 4'b0110, S_WIN = 4'b0111,
        S_BUSY = 4'b1000, S_HOLD = 4'b1001, S_P1 = 4'b1010, S_P2 = 4'b1011,
        S_LSET = 4'b1100, S_LQRY = 4'b1101, S_LIFT = 4'b1110
    } fcd_state_t;
    typedef enum logic [1:0] {
        RM_ARRAY = 2'b00, RM_STATUS = 2'b01, RM_LOCK = 2'b10
    } fcd_rmode_t;
endpackage : fcd_pkg

// [hdl/fcd_if.sv]
// CPU-side write/read channel between the host driver and the command decoder
`timescale 1ns/1ns
`default_nettype none
interface fcd_if;
    import fcd_pkg::*;
    logic wr;
    logic rd;
    logic from_flash;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    modport dev (input wr, rd, from_flash, addr, wdata, output rdata, rvalid);
    modport host (output wr, rd, from_flash, addr, wdata, input rdata, rvalid);
endinterface : fcd_if
`default_nettype wire

// [hdl/fcd_host.sv]
// CPU-side sequencer that issues the coded write sequences to the decoder
`timescale 1ns/1ns
`default_nettype none
module fcd_host
    import fcd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    fcd_if.host bus,
    input wire logic i_start,
    input wire logic [3:0] i_cmd,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_data,
    input wire logic i_rd,
    output logic o_busy,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_rvalid
);
    // Command codes: 0 reset,1 long reset,2 program,3 sector wipe,4 chip wipe,
    // 5 hold,6 continue,7 lock set,8 lock query,9 sector lift,10 code lift,11 restore
    typedef struct packed {
        logic [2:0] idx;
        logic [2:0] len;
        logic [3:0] cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic busy;
        logic wr;
        logic rd;
        logic ff;
        logic [ADDR_W-1:0] baddr;
        logic [DATA_W-1:0] bdata;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
    } fcd_host_t;

    fcd_host_t s_r;
    fcd_host_t s_nxt;

    function automatic logic [2:0] seq_len(input logic [3:0] c);
        case (c)
            4'h1, 4'h8: seq_len = 3'd3;
            4'h2, 4'h7, 4'h9: seq_len = 3'd4;
            4'h3, 4'h4: seq_len = 3'd6;
            default: seq_len = 3'd1;
        endcase
    endfunction : seq_len

    function automatic logic [13:0] ul_a(input logic prot, input logic [2:0] i);
        ul_a = prot ? ((i == 3'd1) ? CA_15A8 : CA_2A54)
                    : ((i == 3'd1 || i == 3'd4) ? CA_2AA8 : CA_1554);
    endfunction : ul_a

    logic prot;
    logic [7:0] cd;
    logic [ADDR_W-1:0] ca;
    logic [DATA_W-1:0] cw;
    assign prot = (s_r.cmd >= 4'h7 && s_r.cmd <= 4'h9);

    always_comb begin
        ca = {{(ADDR_W-14){1'b0}}, ul_a(prot, s_r.idx)};
        case (s_r.idx)
            3'd0, 3'd3: cd = CD_A8;
            3'd1, 3'd4: cd = CD_54;
            default: cd = CD_F0;
        endcase
        if (s_r.idx == 3'd2) begin
            case (s_r.cmd)
                4'h2: cd = CD_A0;
                4'h3, 4'h4: cd = CD_80;
                4'h7: cd = CD_C0;
                4'h8: cd = CD_90;
                4'h9: cd = CD_C1;
                default: cd = CD_F0;
            endcase
        end
        cw = {8'h00, cd};
        if (s_r.idx == s_r.len - 3'd1) begin
            case (s_r.cmd)
                4'h4: cw = {8'h00, CD_10};
                4'h3, 4'h6: cw = {8'h00, CD_30};
                4'h5: cw = {8'h00, CD_B0};
                4'hA: cw = CODE_LIFT;
                4'hB: cw = CODE_RESTORE;
                4'h2, 4'h7: cw = s_r.data;
                4'h8: cw = {8'h00, CD_90};
                default: cw = {8'h00, CD_F0};
            endcase
            if (s_r.cmd != 4'h1 && s_r.cmd != 4'h4 && s_r.cmd != 4'h8 && s_r.cmd != 4'h9) begin
                ca = s_r.addr;
            end
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.wr = 1'b0;
        s_nxt.rd = 1'b0;
        s_nxt.rvalid = bus.rvalid;
        if (bus.rvalid) begin
            s_nxt.rdata = bus.rdata;
        end
        if (!s_r.busy && i_start) begin
            s_nxt.busy = 1'b1;
            s_nxt.cmd = i_cmd;
            s_nxt.len = seq_len(i_cmd);
            s_nxt.idx = 3'd0;
            s_nxt.addr = i_addr;
            s_nxt.data = i_data;
        end else if (s_r.busy) begin
            s_nxt.wr = 1'b1;
            s_nxt.baddr = ca;
            s_nxt.bdata = cw;
            s_nxt.ff = (s_r.cmd == 4'hA || s_r.cmd == 4'hB);
            s_nxt.idx = s_r.idx + 3'd1;
            if (s_r.idx == s_r.len - 3'd1) begin
                s_nxt.busy = 1'b0;
            end
        end else if (i_rd) begin
            s_nxt.rd = 1'b1;
            s_nxt.baddr = i_addr;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.wr = s_r.wr;
    assign bus.rd = s_r.rd;
    assign bus.from_flash = s_r.ff;
    assign bus.addr = s_r.baddr;
    assign bus.wdata = s_r.bdata;
    assign o_busy = s_r.busy;
    assign o_rdata = s_r.rdata;
    assign o_rvalid = s_r.rvalid;
endmodule : fcd_host
`default_nettype wire

// [bench/fcd_checker.sv]
// Assertions on the decoder's CPU channel and its operation outputs
`timescale 1ns/1ns
`default_nettype none
module fcd_checker
    import fcd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic wr,
    input wire logic rd,
    input wire logic from_flash,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic rvalid,
    input wire logic o_prog_go,
    input wire logic o_wipe_go,
    input wire logic o_chip_wipe,
    input wire logic o_wipe_hold,
    input wire logic o_lock_write,
    input wire logic o_code_lock_lift
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Coded command write; only address bits 13:0 take part
    sequence cw(logic [13:0] a, logic [7:0] d);
        wr && !from_flash && addr[13:0] == a && wdata[7:0] == d;
    endsequence

    rd_answer_a: assert property (rd |=> rvalid)
        else $error("read not answered next cycle");
    prog_seq_a: assert property (!o_wipe_go ##0 cw(CA_1554, CD_A8) ##1 cw(CA_2AA8, CD_54)
        ##1 cw(CA_1554, CD_A0) ##1 wr |=> o_prog_go)
        else $error("program sequence did not start programming");
    prog_pulse_a: assert property (o_prog_go |=> !o_prog_go)
        else $error("program start longer than one cycle");
    chip_seq_a: assert property (!o_wipe_go ##0 cw(CA_1554, CD_A8) ##1 cw(CA_2AA8, CD_54)
        ##1 cw(CA_1554, CD_80) ##1 cw(CA_1554, CD_A8) ##1 cw(CA_2AA8, CD_54)
        ##1 cw(CA_1554, CD_10) |-> ##[1:2] (o_chip_wipe && o_wipe_go))
        else $error("chip erase sequence did not start erase");
    lock_seq_a: assert property (cw(CA_2A54, CD_A8) ##1 cw(CA_15A8, CD_54)
        ##1 cw(CA_2A54, CD_C0) ##1 (wr && addr[1:0] == 2'b10) |=> o_lock_write)
        else $error("lock set sequence did not write lock word");
    wipe_hold_a: assert property (o_wipe_go && wr && !from_flash && wdata[7:0] == CD_B0
        |=> o_wipe_hold && !o_wipe_go)
        else $error("suspend did not hold the erase");
    wipe_resume_a: assert property (o_wipe_hold && wr && !from_flash && wdata[7:0] == CD_30
        |=> o_wipe_go && !o_wipe_hold)
        else $error("resume did not restart the erase");
    code_lift_a: assert property (wr && from_flash && wdata == CODE_LIFT
        |=> o_code_lock_lift)
        else $error("code lock not lifted");
    code_restore_a: assert property (wr && from_flash && wdata == CODE_RESTORE
        |=> !o_code_lock_lift)
        else $error("code lock not restored");
    code_guard_a: assert property (!(wr && from_flash) |=> $stable(o_code_lock_lift))
        else $error("code lock changed without a write from flash");

    cover property (o_prog_go);
    cover property (o_wipe_hold);
    cover property (o_lock_write);
endmodule : fcd_checker
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench: the host sequencer drives the decoder over the shared channel
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import fcd_pkg::*;
    // Short erase window keeps the run brief
    localparam int WIN = 20;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic start = 1'b0;
    logic [3:0] cmd = 4'h0;
    logic [ADDR_W-1:0] h_addr = 19'h0_0000;
    logic [DATA_W-1:0] h_data = 16'h0000;
    logic h_rd = 1'b0;
    logic op_done = 1'b0;
    logic op_fail = 1'b0;
    logic h_busy, h_rvalid, prog_go, wipe_go, chip_wipe, hold, lock_wr, sec_lift, code_lift;
    logic [DATA_W-1:0] h_rdata, pdata, lock_val, fsw;
    logic [15:0] blocks;
    logic [ADDR_W-1:0] tgt;
    logic [DATA_W-1:0] q;
    int checked = 0;
    int fail_count = 0;
    int prog_cnt = 0;
    int lock_cnt = 0;

    fcd_if bus();
    // Array contents follow the address so a stale read is visible
    wire logic [DATA_W-1:0] arr = bus.addr[15:0] ^ 16'h3C3C;

    always #2 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        if (prog_go === 1'b1) prog_cnt++;
        if (lock_wr === 1'b1) lock_cnt++;
    end

    fcd_host i_fcd_host (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus), .i_start(start),
        .i_cmd(cmd), .i_addr(h_addr), .i_data(h_data), .i_rd(h_rd), .o_busy(h_busy),
        .o_rdata(h_rdata), .o_rvalid(h_rvalid));
    fcd_decoder #(.WINDOW_CYCLES(WIN), .MAX_BLOCKS(16)) i_fcd_decoder (.i_clk(i_clk),
        .i_rst_b(i_rst_b), .bus(bus), .i_op_done(op_done), .i_op_fail(op_fail),
        .i_array_data(arr), .o_prog_go(prog_go), .o_wipe_go(wipe_go),
        .o_chip_wipe(chip_wipe), .o_wipe_blocks(blocks), .o_wipe_hold(hold),
        .o_target_location(tgt), .o_prog_data(pdata), .o_lock_write(lock_wr),
        .o_lock_write_value(lock_val), .o_sector_lock_lift(sec_lift),
        .o_code_lock_lift(code_lift), .o_flash_status_word(fsw));
    fcd_checker i_fcd_checker (.i_clk(i_clk), .i_rst_b(i_rst_b), .wr(bus.wr), .rd(bus.rd),
        .from_flash(bus.from_flash), .addr(bus.addr), .wdata(bus.wdata),
        .rvalid(bus.rvalid), .o_prog_go(prog_go), .o_wipe_go(wipe_go),
        .o_chip_wipe(chip_wipe), .o_wipe_hold(hold), .o_lock_write(lock_wr),
        .o_code_lock_lift(code_lift));

    task automatic give_verdict();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wait_idle();
        int n;
        n = 0;
        #1;
        while (h_busy !== 1'b0) begin
            if (n == 60) begin
                fail_count++;
                $display("Error at %0t: busy stuck, got %h expected %h", $time, h_busy, 1'b0);
                give_verdict();
            end
            @(posedge i_clk);
            #1;
            n++;
        end
    endtask : wait_idle

    task automatic run_cmd(input logic [3:0] c, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
        wait_idle();
        @(posedge i_clk);
        start <= 1'b1;
        cmd <= c;
        h_addr <= a;
        h_data <= d;
        @(posedge i_clk);
        start <= 1'b0;
        @(posedge i_clk);
        wait_idle();
        repeat (2) @(posedge i_clk);
        #1;
    endtask : run_cmd

    task automatic rd_word(input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        wait_idle();
        @(posedge i_clk);
        h_rd <= 1'b1;
        h_addr <= a;
        @(posedge i_clk);
        h_rd <= 1'b0;
        #1;
        while (h_rvalid !== 1'b1) begin
            if (n == 20) begin
                fail_count++;
                $display("Error at %0t: no read answer, got %h expected %h", $time, h_rvalid, 1'b1);
                give_verdict();
            end
            @(posedge i_clk);
            #1;
            n++;
        end
        q = h_rdata;
    endtask : rd_word

    task automatic finish_op(input logic f);
        @(posedge i_clk);
        op_done <= 1'b1;
        op_fail <= f;
        @(posedge i_clk);
        op_done <= 1'b0;
        op_fail <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask : finish_op

    task automatic t_read_reset();
        run_cmd(4'h0, 19'h7_C000, 16'h00F0);
        rd_word(19'h0_0124);
        check(q, 16'h0124 ^ 16'h3C3C);
        run_cmd(4'h1, 19'h0_0000, 16'h00F0);
        rd_word(19'h0_0456);
        check(q, 16'h0456 ^ 16'h3C3C);
    endtask : t_read_reset

    task automatic t_program();
        run_cmd(4'h2, 19'h4_1234, 16'hBEEF);
        check(prog_cnt, 1);
        check(tgt, 19'h4_1234);
        check(pdata, 16'hBEEF);
        rd_word(19'h4_1234);
        check(q[STAT_DONE], 1'b0);
        // Lock lift must be refused while programming runs
        run_cmd(4'h9, 19'h0_0000, 16'h00C1);
        check(sec_lift, 1'b0);
        finish_op(1'b0);
        run_cmd(4'h0, 19'h0_0000, 16'h00F0);
        rd_word(19'h0_0200);
        check(q, 16'h0200 ^ 16'h3C3C);
        check(prog_cnt, 1);
    endtask : t_program

    task automatic t_block_wipe();
        run_cmd(4'h3, 19'h1_8010, 16'h0030);
        run_cmd(4'h6, 19'h2_8000, 16'h0030);
        check(blocks, 16'h0028);
        rd_word(19'h0_0000);
        check(q[STAT_WIN], 1'b0);
        repeat (WIN + 5) @(posedge i_clk);
        rd_word(19'h0_0000);
        check(q[STAT_WIN], 1'b1);
        check(q[STAT_DONE], 1'b0);
        run_cmd(4'h5, 19'h1_8010, 16'h00B0);
        check({hold, wipe_go}, 2'b10);
        run_cmd(4'h2, 19'h0_0040, 16'h1234);
        check(pdata, 16'h1234);
        finish_op(1'b0);
        check({hold, wipe_go}, 2'b10);
        run_cmd(4'h6, 19'h0_0000, 16'h0030);
        check({hold, wipe_go}, 2'b01);
        finish_op(1'b0);
        check(wipe_go, 1'b0);
        run_cmd(4'h0, 19'h0_0000, 16'h00F0);
    endtask : t_block_wipe

    task automatic t_chip_wipe();
        run_cmd(4'h4, 19'h0_0000, 16'h0010);
        check({chip_wipe, wipe_go}, 2'b11);
        finish_op(1'b1);
        rd_word(19'h0_0000);
        check({q[STAT_DONE], q[STAT_ERR]}, 2'b11);
        run_cmd(4'h0, 19'h0_0000, 16'h00F0);
        rd_word(19'h0_0010);
        check(q, 16'h0010 ^ 16'h3C3C);
    endtask : t_chip_wipe

    task automatic t_lock();
        run_cmd(4'h7, 19'h0_0006, 16'h7FFE);
        check(lock_cnt, 1);
        check(lock_val, 16'h7FFE);
        run_cmd(4'h7, 19'h0_0002, 16'hFFFF);
        rd_word(19'h0_0000);
        check(q[STAT_ERR], 1'b1);
        run_cmd(4'h8, 19'h0_0002, 16'h0090);
        rd_word(19'h0_000A);
        check(q, 16'h7FFE);
        run_cmd(4'h0, 19'h0_0000, 16'h00F0);
        run_cmd(4'h9, 19'h0_0000, 16'h00C1);
        check(sec_lift, 1'b1);
    endtask : t_lock

    task automatic t_code();
        run_cmd(4'hA, 19'h0_1000, 16'hFFFF);
        check(code_lift, 1'b1);
        run_cmd(4'hB, 19'h0_1000, 16'hFFFB);
        check(code_lift, 1'b0);
        run_cmd(4'hA, 19'h0_1000, 16'hFFFF);
        // A second reset must drop both temporary lifts
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        #1;
        check({sec_lift, code_lift}, 2'b00);
    endtask : t_code

    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_read_reset();
        t_program();
        t_block_wipe();
        t_chip_wipe();
        t_lock();
        t_code();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
